// *** rtl/lpd_top.sv ***
// Local-oscillator programmable divider with its serial control port and APB view.
// Assumes LO inputs and serial pins are asynchronous to CLK and much slower than it.
//
// The register offsets and the APB register port were left to the implementer.
`timescale 1ns/1ps
module lpd_top (
	input  wire logic        CLK,
	input  wire logic        RESET,
	input  wire logic        HIGH_BAND_LO_INPUT,
	input  wire logic        LOW_BAND_LO_INPUT,
	input  wire logic        CHIP_SELECT,
	input  wire logic        SHIFT_TIMING_PIN,
	input  wire logic        SERIAL_IN_PIN,
	output logic             SERIAL_OUT,
	output logic             SERIAL_OUT_OE,
	output logic             DIV_OUT,
	input  wire logic        PSEL,
	input  wire logic        PENABLE,
	input  wire logic        PWRITE,
	input  wire logic [7:0]  PADDR,
	input  wire logic [31:0] PWDATA,
	output logic [31:0]      PRDATA,
	output logic             PREADY,
	output logic             PSLVERR
);

	function automatic logic rise(input logic prev, input logic cur);
		return cur & ~prev;
	endfunction

	function automatic logic in_range(input logic [15:0] n, input logic [15:0] lo,
		input logic [15:0] hi);
		return (n >= lo) && (n <= hi);
	endfunction

	// Pin synchronisers: stage one feeds only stage two.
	logic [4:0] sync1;
	logic [4:0] sync2;
	logic [4:0] sync3;

	always_ff @(posedge CLK) begin
		sync1 <= {SERIAL_IN_PIN, SHIFT_TIMING_PIN, CHIP_SELECT, LOW_BAND_LO_INPUT,
			HIGH_BAND_LO_INPUT};
		sync2 <= sync1;
		sync3 <= sync2;
	end

	wire hf_s   = sync2[0];
	wire lf_s   = sync2[1];
	wire ce_s   = sync2[2];
	wire cl_s   = sync2[3];
	wire di_s   = sync2[4];
	wire ce_rise = rise(sync3[2], ce_s);
	wire ce_fall = rise(ce_s, sync3[2]);
	wire cl_rise = rise(sync3[3], cl_s);
	wire cl_fall = rise(cl_s, sync3[3]);

	// Serial control input.
	lpd_pkg::lpd_ctrl_s ctrl;
	logic [23:0]        shift_in;
	logic [4:0]         bit_count;
	logic               frame_error;
	wire                frame_done = ce_fall && (bit_count == lpd_pkg::LPD_FRAME_BITS);

	always_ff @(posedge CLK) begin
		if (RESET) begin
			ctrl        <= lpd_pkg::LPD_RST_CTRL;
			shift_in    <= 24'h000000;
			bit_count   <= 5'h00;
			frame_error <= 1'b0;
		end else begin
			if (ce_s && cl_rise) begin
				shift_in <= {di_s, shift_in[23:1]};
				if (bit_count != 5'h1F)
					bit_count <= bit_count + 5'h01;
			end else if (ce_rise) begin
				bit_count <= 5'h00;
			end
			// A short or long frame is dropped whole so a torn word never steers the divider.
			if (frame_done)
				ctrl <= shift_in;
			if (ce_fall)
				frame_error <= ~frame_done;
		end
	end

	// Path decode and divisor selection.
	lpd_pkg::lpd_path_e path;
	lpd_pkg::lpd_path_e next_path;
	logic [15:0]        div_n;
	logic               div_ok;

	assign next_path = ctrl.band_input_select ? lpd_pkg::LPD_PATH_PRESCALE :
		(ctrl.am_path_select ? lpd_pkg::LPD_PATH_SWALLOW :
		lpd_pkg::LPD_PATH_DIRECT);

	always_comb begin
		unique case (path)
			lpd_pkg::LPD_PATH_PRESCALE: begin
				div_n  = ctrl.divisor;
				div_ok = in_range(ctrl.divisor, lpd_pkg::LPD_SWALLOW_MIN,
					lpd_pkg::LPD_SWALLOW_MAX);
			end
			lpd_pkg::LPD_PATH_SWALLOW: begin
				div_n  = ctrl.divisor;
				div_ok = in_range(ctrl.divisor, lpd_pkg::LPD_SWALLOW_MIN,
					lpd_pkg::LPD_SWALLOW_MAX);
			end
			lpd_pkg::LPD_PATH_DIRECT: begin
				div_n  = {4'h0, ctrl.divisor[11:0]};
				div_ok = in_range(div_n, lpd_pkg::LPD_DIRECT_MIN, lpd_pkg::LPD_DIRECT_MAX);
			end
			default: begin
				div_n  = 16'h0000;
				div_ok = 1'b0;
			end
		endcase
	end

	// Divider chain.
	logic        enable;
	logic        prescale;
	logic [15:0] cnt;
	logic [15:0] pulse_count;
	wire         lo_sel  = (path == lpd_pkg::LPD_PATH_PRESCALE) ? hf_s : lf_s;
	wire         lo_prev = (path == lpd_pkg::LPD_PATH_PRESCALE) ? sync3[0] : sync3[1];
	wire         lo_edge = rise(lo_prev, lo_sel);
	wire         is_high = (path == lpd_pkg::LPD_PATH_PRESCALE);
	wire         tick    = lo_edge && (!is_high || prescale);
	wire         run     = enable && div_ok && (path == next_path);
	wire         wrap    = run && tick && (cnt == 16'h0000);

	always_ff @(posedge CLK) begin
		if (RESET) begin
			path        <= lpd_pkg::LPD_PATH_DIRECT;
			prescale    <= 1'b0;
			cnt         <= 16'h0000;
			DIV_OUT     <= 1'b0;
			pulse_count <= 16'h0000;
		end else begin
			path    <= next_path;
			DIV_OUT <= wrap;
			if (!run) begin
				// Restart cleanly whenever the path changes or the divisor is unusable.
				prescale <= 1'b0;
				cnt      <= 16'h0000;
			end else begin
				if (is_high && lo_edge)
					prescale <= ~prescale;
				if (tick)
					cnt <= (cnt == 16'h0000) ? div_n - 16'h0001 : cnt - 16'h0001;
			end
			if (wrap)
				pulse_count <= pulse_count + 16'h0001;
		end
	end

	lpd_pkg::lpd_status_s status;
	assign status = '{frame_error: frame_error, path: path, range_ok: div_ok};

	// Serial output: loaded at chip-select rise, advanced on shift-clock fall.
	logic [23:0] out_shift;
	logic [23:0] content;

	assign content = (ctrl.output_content_select == lpd_pkg::LPD_OUT_COUNT)  ?
		{8'h00, pulse_count} :
		(ctrl.output_content_select == lpd_pkg::LPD_OUT_CTRL)   ? ctrl :
		(ctrl.output_content_select == lpd_pkg::LPD_OUT_STATUS) ? {19'h00000, status} :
		24'h000000;

	always_ff @(posedge CLK) begin
		if (RESET) begin
			out_shift     <= 24'h000000;
			SERIAL_OUT    <= 1'b0;
			SERIAL_OUT_OE <= 1'b0;
		end else begin
			SERIAL_OUT_OE <= ce_s;
			if (ce_rise) begin
				out_shift  <= content;
				SERIAL_OUT <= content[0];
			end else if (ce_s && cl_fall) begin
				out_shift  <= {1'b0, out_shift[23:1]};
				SERIAL_OUT <= out_shift[1];
			end
		end
	end

	// APB slave with one wait state so every answer comes from a flip-flop.
	wire        apb_access = PSEL && PENABLE && !PREADY;
	wire        apb_done   = PSEL && PENABLE && PREADY;
	wire        hit_ctrl   = (PADDR == lpd_pkg::LPD_OFS_CTRL);
	wire        hit_config = (PADDR == lpd_pkg::LPD_OFS_CONFIG);
	wire        hit_status = (PADDR == lpd_pkg::LPD_OFS_STATUS);
	wire        hit_count  = (PADDR == lpd_pkg::LPD_OFS_COUNT);
	wire        hit_any    = hit_ctrl || hit_config || hit_status || hit_count;
	wire [31:0] rd_word    = hit_ctrl   ? {31'h00000000, enable} :
		hit_config ? {8'h00, ctrl} :
		hit_status ? {27'h0000000, status} :
		hit_count  ? {16'h0000, pulse_count} : 32'h00000000;

	always_ff @(posedge CLK) begin
		if (RESET) begin
			PREADY  <= 1'b0;
			PSLVERR <= 1'b0;
			PRDATA  <= 32'h00000000;
			enable  <= lpd_pkg::LPD_RST_ENABLE;
		end else begin
			PREADY  <= apb_access;
			PSLVERR <= apb_access && !hit_any;
			PRDATA  <= (apb_access && !PWRITE) ? rd_word : 32'h00000000;
			if (apb_done && PWRITE && hit_ctrl)
				enable <= PWDATA[lpd_pkg::LPD_CTRL_ENABLE_BIT];
		end
	end

	default clocking cb @(posedge CLK); endclocking
	default disable iff (RESET);

	// Routing is checked from the control bit one cycle later, in the cycle that the path register has followed it.
	chk_band_high_route: assert property (ctrl.band_input_select == 1'b1 |=>
		lo_sel == hf_s)
		else $error("High band select does not use the high-band input.");
	chk_band_low_route: assert property (ctrl.band_input_select == 1'b0 |=>
		lo_sel == lf_s)
		else $error("Low band select does not use the low-band input.");
	chk_prescale_half: assert property (run && is_high && lo_edge && !prescale |->
		!tick ##1 prescale)
		else $error("Prescaler does not swallow every other edge.");
	chk_range_gate: assert property (!div_ok |=> !DIV_OUT)
		else $error("Divided output while divisor is out of range.");
	chk_swallow_direct: assert property (run && path == lpd_pkg::LPD_PATH_SWALLOW &&
		lo_edge |=> cnt != $past(cnt))
		else $error("Low band swallow path does not count every edge.");
	chk_twelve_bit: assert property (path == lpd_pkg::LPD_PATH_DIRECT |->
		cnt[15:12] == 4'h0)
		else $error("Direct divider count uses more than twelve bits.");
	chk_serial_shift: assert property (ce_s && cl_rise |=>
		shift_in[23] == $past(di_s))
		else $error("Serial input bit not captured.");
	chk_frame_latch: assert property (frame_done |=> ctrl == $past(shift_in))
		else $error("Completed frame not latched into control.");
	chk_out_content: assert property (ce_rise |=> out_shift == $past(content))
		else $error("Serial output not loaded from selected content.");
	chk_out_timing: assert property ($changed(SERIAL_OUT) |->
		$past(ce_rise || (ce_s && cl_fall)))
		else $error("Serial output changed away from the shift clock.");
	// The default disable would kill every attempt of this one, so it opts out.
	chk_reset_ctrl: assert property (@(posedge CLK) disable iff (1'b0) RESET |=>
		ctrl == lpd_pkg::LPD_RST_CTRL)
		else $error("Control word not at default after reset.");
	chk_div_pulse: assert property (wrap |=> DIV_OUT ##1 !DIV_OUT)
		else $error("Divided output pulse wrong.");

	cov_high_pulse: cover property (is_high && wrap);
	cov_swallow_pulse: cover property (path == lpd_pkg::LPD_PATH_SWALLOW && wrap);
	cov_direct_pulse: cover property (path == lpd_pkg::LPD_PATH_DIRECT && wrap);
	cov_frame_latch: cover property (frame_done);
	cov_apb_error: cover property (PSLVERR);

endmodule

// *** shared/lpd_pkg.sv ***
// Constants and types for the local-oscillator programmable divider.
// Assumes a single 100 MHz system clock and an APB register bus.
package lpd_pkg;

	// APB register byte offsets.
	localparam logic [7:0] LPD_OFS_CTRL   = 8'h00;
	localparam logic [7:0] LPD_OFS_CONFIG = 8'h04;
	localparam logic [7:0] LPD_OFS_STATUS = 8'h08;
	localparam logic [7:0] LPD_OFS_COUNT  = 8'h0C;

	// Field positions.
	localparam int LPD_CTRL_ENABLE_BIT = 0;
	localparam int LPD_STAT_RANGE_BIT  = 0;
	localparam int LPD_STAT_PATH_LSB   = 1;
	localparam int LPD_STAT_FRAME_BIT  = 4;

	// Reset values.
	localparam logic        LPD_RST_ENABLE = 1'b1;
	localparam logic [23:0] LPD_RST_CTRL   = 24'h000000;

	// Divisor limits per path and serial frame length.
	localparam logic [15:0] LPD_SWALLOW_MIN = 16'h0110;
	localparam logic [15:0] LPD_SWALLOW_MAX = 16'hFFFF;
	localparam logic [15:0] LPD_DIRECT_MIN  = 16'h0004;
	localparam logic [15:0] LPD_DIRECT_MAX  = 16'h0FFF;
	localparam logic [4:0]  LPD_FRAME_BITS  = 5'h18;

	// Output content select codes.
	localparam logic [2:0] LPD_OUT_COUNT  = 3'h0;
	localparam logic [2:0] LPD_OUT_CTRL   = 3'h1;
	localparam logic [2:0] LPD_OUT_STATUS = 3'h2;

	// Serial control word, first bit shifted in lands in divisor[0].
	typedef struct packed {
		logic [2:0]  reserved;
		logic [2:0]  output_content_select;
		logic        am_path_select;
		logic        band_input_select;
		logic [15:0] divisor;
	} lpd_ctrl_s;

	typedef struct packed {
		logic       frame_error;
		logic [2:0] path;
		logic       range_ok;
	} lpd_status_s;

	typedef enum logic [2:0] {
		LPD_PATH_PRESCALE = 3'b001,
		LPD_PATH_SWALLOW  = 3'b010,
		LPD_PATH_DIRECT   = 3'b100
	} lpd_path_e;

endpackage

// *** testbench/lpd_far_side.sv ***
// Model of the tuner oscillators and of the serial controller beside the divider.
// Assumes clk is at least four times faster than any pin edge made here.
`timescale 1ns/1ps
module lpd_far_side (
	input  wire logic clk,
	input  wire logic so,
	output logic      hb,
	output logic      lb,
	output logic      cs,
	output logic      sck,
	output logic      sdi
);
	initial begin
		{hb, lb, cs, sck, sdi} = 5'h00;
	end

	task automatic wt(input int n);
		repeat (n) @(posedge clk);
	endtask

	// Levels are held four cycles because the design samples pins through two flip-flops.
	task automatic lo(input logic hi, input int n);
		repeat (n) begin
			wt(4);
			if (hi) begin
				hb <= 1'b1;
			end else begin
				lb <= 1'b1;
			end
			wt(4);
			hb <= 1'b0;
			lb <= 1'b0;
		end
	endtask

	task automatic frame(input logic [23:0] w, input int n, output logic [23:0] q);
		q = 24'h000000;
		cs <= 1'b1;
		wt(5);
		for (int i = 0; i < n; i++) begin
			sdi <= w[i];
			wt(4);
			q[i] = so;
			sck <= 1'b1;
			wt(4);
			sck <= 1'b0;
			wt(4);
		end
		cs <= 1'b0;
		// The released data line must not keep showing the last bit.
		sdi <= ~sdi;
		wt(6);
	endtask
endmodule

// *** testbench/tb_lo_programmable_divider.sv ***
// Self-checking bench for the programmable divider: APB, serial link and divider paths.
// Assumes the far side model drives the oscillator and serial pins.
`timescale 1ns/1ps
module tb_lo_programmable_divider;
	logic        clk, reset, psel, penable, pwrite, pready, pslverr;
	logic        serial_out, serial_out_oe, div_out, hb, lb, cs, sck, sdi;
	logic [7:0]  paddr;
	logic [31:0] pwdata, prdata;
	int          fail_count = 0;
	int          checked = 0;
	int          seed = 32655;
	int          pulses = 0;
	int          seen_div = 0;
	logic [32:0] expq[$];

	lpd_top i_dut (.CLK(clk), .RESET(reset), .HIGH_BAND_LO_INPUT(hb), .LOW_BAND_LO_INPUT(lb),
		.CHIP_SELECT(cs), .SHIFT_TIMING_PIN(sck), .SERIAL_IN_PIN(sdi), .SERIAL_OUT(serial_out),
		.SERIAL_OUT_OE(serial_out_oe), .DIV_OUT(div_out), .PSEL(psel), .PENABLE(penable),
		.PWRITE(pwrite), .PADDR(paddr), .PWDATA(pwdata), .PRDATA(prdata), .PREADY(pready),
		.PSLVERR(pslverr));
	lpd_far_side i_far (.clk(clk), .so(serial_out), .hb(hb), .lb(lb), .cs(cs), .sck(sck),
		.sdi(sdi));

	initial begin
		clk = 1'b0;
		forever #5 clk = ~clk;
	end

	task automatic check(input string nm, input logic [32:0] seen, input logic [32:0] exp);
		checked++;
		if (seen !== exp) begin
			fail_count++;
			$display("mismatch %s expected %h seen %h", nm, exp, seen);
		end
	endtask

	task automatic complete_run();
		$display("counts: %0d checked, %0d mismatches", checked, fail_count);
		if (fail_count == 0 && checked > 0) $display("RESULT: PASS");
		else $display("RESULT: FAIL");
		$finish;
	endtask

	// Each transfer notes {error, read data} that the answer must carry.
	task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] d,
		input logic [32:0] e);
		expq.push_back(e);
		psel <= 1'b1;
		pwrite <= wr;
		paddr <= a;
		pwdata <= d;
		@(posedge clk);
		penable <= 1'b1;
		do @(posedge clk); while (pready !== 1'b1);
		psel <= 1'b0;
		penable <= 1'b0;
		// One idle edge keeps the next call from driving psel twice in one step.
		@(posedge clk);
	endtask

	always @(posedge clk) begin
		if (pready === 1'b1) begin
			check("apb answer", {pslverr, prdata}, expq.pop_front());
		end
		if (div_out === 1'b1) begin
			seen_div++;
		end
	end

	initial begin
		repeat (95000) @(posedge clk);
		fail_count++;
		complete_run();
	end

	initial begin
		logic [23:0] w, q;
		logic [23:0] ex[4];
		logic [1:0]  sel[7] = '{2'h2, 2'h1, 2'h0, 2'h0, 2'h0, 2'h1, 2'h3};
		logic [15:0] dv[7] = '{16'h0110, 16'h0110, 16'h0004, 16'h0004, 16'h0FFF, 16'h010F,
			16'h0110};
		int          edges[7] = '{1088, 544, 8, 8, 4095, 542, 544};
		int          add[7] = '{2, 2, 0, 2, 1, 0, 0};
		logic [4:0]  st[7] = '{5'h03, 5'h05, 5'h09, 5'h09, 5'h09, 5'h04, 5'h03};
		{reset, psel, penable, pwrite, paddr, pwdata} = 44'h80000000000;
		repeat (12) @(posedge clk);
		reset <= 1'b0;
		repeat (3) @(posedge clk);
		apb(1'b0, lpd_pkg::LPD_OFS_CTRL, 32'h0, 33'h000000001);
		apb(1'b0, lpd_pkg::LPD_OFS_STATUS, 32'h0, 33'h000000008);
		apb(1'b1, lpd_pkg::LPD_OFS_CONFIG, $random(seed), 33'h0);
		apb(1'b0, lpd_pkg::LPD_OFS_CONFIG, 32'h0, 33'h0);
		apb(1'b1, 8'h10, $random(seed), 33'h100000000);
		apb(1'b0, 8'h10, 32'h0, 33'h100000000);
		$display("test registers done");
		// Edge counts are whole multiples of the ratio, so the phase at restart never matters.
		for (int r = 0; r < 7; r++) begin
			// Each sel entry holds the band select above the low band path select.
			w = {6'h00, sel[r][0], sel[r][1], dv[r]};
			i_far.frame(w, 24, q);
			apb(1'b1, lpd_pkg::LPD_OFS_CTRL, {31'h0, r != 2}, 33'h0);
			apb(1'b0, lpd_pkg::LPD_OFS_CONFIG, 32'h0, {9'h000, w});
			apb(1'b0, lpd_pkg::LPD_OFS_STATUS, 32'h0, {28'h0, st[r]});
			i_far.lo(r == 0, edges[r]);
			repeat (6) @(posedge clk);
			pulses += add[r];
			apb(1'b0, lpd_pkg::LPD_OFS_COUNT, 32'h0, 33'(pulses));
			check("div pulses", 33'(seen_div), 33'(pulses));
			$display("test path %0d done", r);
		end
		i_far.frame(24'h000000, 23, q);
		apb(1'b0, lpd_pkg::LPD_OFS_STATUS, 32'h0, 33'h000000013);
		apb(1'b0, lpd_pkg::LPD_OFS_CONFIG, 32'h0, {9'h000, w});
		for (int c = 0; c < 4; c++) begin
			w = {3'h0, 3'(c), 2'h0, 16'h0004};
			i_far.frame(w, 24, q);
			i_far.frame(w, 24, q);
			ex = '{{8'h00, pulses[15:0]}, w, 24'h000009, 24'h000000};
			check("serial out", {9'h000, q}, {9'h000, ex[c]});
			check("out enable idle", {32'h0, serial_out_oe}, 33'h0);
		end
		$display("test serial out done");
		repeat (4) @(posedge clk);
		complete_run();
	end
endmodule
